// ---- mailbox_params.svh ----
/*
  constants for the host status and command mailbox: register offsets,
  status bit positions, control bit positions and reset values.
  assumes inclusion by bare name from the design, checker and bench files.
*/
`ifndef MAILBOX_PARAMS_SVH
`define MAILBOX_PARAMS_SVH

// host-side register word offsets (byte addresses, aligned words)
`define OFF_HW_STATUS 8'h00
`define OFF_HW_CONTROL 8'h04
`define OFF_CMD 8'h08
`define OFF_AUX_CMD 8'h0c
`define OFF_REPLY 8'h10
`define OFF_AUX_REPLY 8'h14
`define OFF_IRQ_STATUS 8'h18
`define OFF_IRQ_MASK 8'h1c

// hardware status bit positions
`define ST_CTRL_RDY 0
`define ST_AUX_CTRL_RDY 1
`define ST_REPLY_RDY 2
`define ST_AUX_REPLY_RDY 3
`define ST_RX_RDY 4
`define ST_TX_RDY 5
`define ST_RX_DMA 6
`define ST_TX_DMA 7
`define ST_SLEEP 14
`define ST_PIN_MIRROR 15

// hardware control bit positions
`define CT_RX_IE 0
`define CT_REPLY_IE 1
`define CT_AUX_REPLY_IE 2
`define CT_TX_DMA_EN 3
`define CT_RX_DMA_EN 4
`define CT_MASTER_IE 5
`define CT_WAKE 6

`define HW_CONTROL_RESET 16'h0000
`define WORD_RESET 16'h0000
`define IRQ_BITS 4

`endif

// ---- mailbox_pkg.sv ----
/*
  types for the host status and command mailbox.
  assumes mailbox_params.svh on the include path.
*/
package mailbox_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0] reg_addr_t;
endpackage

// ---- host_status_command_mailbox.sv ----
/*
  host status and command mailbox: status flags, reply and command
  semaphores with auxiliary twins, host interrupt qualification, and a
  register port for host software.
  assumes one clock, core-side strobes synchronous to core_clk, and
  async pins (dma requests, sleep) passed through two flip-flops here.
*/
// Our own choices: the register addresses and the plain strobed port.
// Operation
// - tx dma flag follows tx dma request, zero while tx dma disabled.
// - rx ready mirrors buffer ownership, clear after reset.
// - interrupt while rx ready set and its enable set.
// - rx dma flag follows rx dma request, zero while rx dma disabled.
// - reply ready set on core status write, cleared by host high read.
// - interrupt while reply ready set and its enable set.
// - pin mirror shows interrupt pin level, zero if master disabled.
// - control ready set on core command read, cleared by host high write.
// - core does one dummy command read after reset to set control ready.
// - aux reply ready set by core aux write, cleared by host high read.
// - interrupt while aux reply ready set and its enable set.
// - aux control ready set by core aux read, cleared by host write.
// - core does one dummy aux command read when ready.
// - other status bits undefined while sleep flag active.
// - command register is 16 bits, host reads back last command.
// - aux command register exists with same handshake, firmware unused.
`timescale 1ns/1ps
`include "mailbox_params.svh"

module host_status_command_mailbox
  import mailbox_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  // host register port
  input wire reg_addr_t addr,
  input wire word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output word_t rdata,
  // host byte-wide strobes
  input wire logic host_cmd_hi_wr,
  input wire logic host_aux_cmd_hi_wr,
  input wire logic host_reply_hi_rd,
  input wire logic host_aux_reply_hi_rd,
  // internal core side
  input wire logic core_cmd_rd,
  input wire logic core_aux_cmd_rd,
  input wire logic core_reply_wr,
  input wire logic core_aux_reply_wr,
  input wire word_t core_wdata,
  output word_t core_cmd,
  output word_t core_aux_cmd,
  // buffer ownership bits from the buffer blocks
  input wire logic rx_buffer_owned,
  input wire logic tx_buffer_owned,
  // async input pins, then the synchronous interrupt and wake outputs
  input wire logic tx_dma_request,
  input wire logic rx_dma_request,
  input wire logic interface_sleep,
  output logic host_interrupt_n,
  output logic wake_pulse,
  output logic irq
);

  // two-flop synchronisers for the async pins
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {interface_sleep, rx_dma_request, tx_dma_request};
      sync2_q <= sync1_q;
    end
  end
  wire tx_dreq_s = sync2_q[0];
  wire rx_dreq_s = sync2_q[1];
  wire interface_sleep_flag = sync2_q[2];

  // register decode
  wire sel_ctrl = addr == `OFF_HW_CONTROL;
  wire sel_cmd = addr == `OFF_CMD;
  wire sel_aux = addr == `OFF_AUX_CMD;
  wire sel_ist = addr == `OFF_IRQ_STATUS;
  wire sel_msk = addr == `OFF_IRQ_MASK;
  wire wr_ctrl = wr && sel_ctrl;
  wire wr_cmd = wr && sel_cmd;
  wire wr_aux = wr && sel_aux;

  word_t hw_control_q;
  word_t cmd_q;
  word_t aux_cmd_q;
  word_t reply_q;
  word_t aux_reply_q;
  logic ctrl_rdy_q;
  logic aux_ctrl_rdy_q;
  logic reply_rdy_q;
  logic aux_reply_rdy_q;
  logic [`IRQ_BITS-1:0] irq_status_q;
  logic [`IRQ_BITS-1:0] irq_mask_q;
  logic pin_q;
  word_t rdata_q;
  logic wake_q;

  wire rx_ie = hw_control_q[`CT_RX_IE];
  wire reply_ie = hw_control_q[`CT_REPLY_IE];
  wire aux_reply_ie = hw_control_q[`CT_AUX_REPLY_IE];
  wire tx_dma_en = hw_control_q[`CT_TX_DMA_EN];
  wire rx_dma_en = hw_control_q[`CT_RX_DMA_EN];
  wire master_ie = hw_control_q[`CT_MASTER_IE];

  // host-side command writes: a full word write counts as a high-byte write
  wire cmd_hi_wr = host_cmd_hi_wr || wr_cmd;
  wire aux_hi_wr = host_aux_cmd_hi_wr || wr_aux;

  // control word: written by the host only
  wire word_t hw_control_d = wr_ctrl ? wdata : hw_control_q;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hw_control_q <= `HW_CONTROL_RESET;
    end
    else
    begin
      hw_control_q <= hw_control_d;
    end
  end

  // command words: a host read returns the last word written
  wire word_t cmd_d = wr_cmd ? wdata : cmd_q;
  wire word_t aux_cmd_d = wr_aux ? wdata : aux_cmd_q;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_q <= `WORD_RESET;
    end
    else
    begin
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aux_cmd_q <= `WORD_RESET;
    end
    else
    begin
      aux_cmd_q <= aux_cmd_d;
    end
  end

  // reply words: loaded by the core only
  wire word_t reply_d = core_reply_wr ? core_wdata : reply_q;
  wire word_t aux_reply_d = core_aux_reply_wr ? core_wdata : aux_reply_q;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reply_q <= `WORD_RESET;
    end
    else
    begin
      reply_q <= reply_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aux_reply_q <= `WORD_RESET;
    end
    else
    begin
      aux_reply_q <= aux_reply_d;
    end
  end

  // semaphores: the core-side set wins over a same-cycle host clear
  wire ctrl_rdy_set = core_cmd_rd;
  wire ctrl_rdy_clr = cmd_hi_wr;
  wire aux_ctrl_rdy_set = core_aux_cmd_rd;
  wire aux_ctrl_rdy_clr = aux_hi_wr;
  wire reply_rdy_set = core_reply_wr;
  wire reply_rdy_clr = host_reply_hi_rd;
  wire aux_reply_rdy_set = core_aux_reply_wr;
  wire aux_reply_rdy_clr = host_aux_reply_hi_rd;
  wire ctrl_rdy_d = ctrl_rdy_set | (ctrl_rdy_q & ~ctrl_rdy_clr);
  wire aux_ctrl_rdy_d = aux_ctrl_rdy_set |
    (aux_ctrl_rdy_q & ~aux_ctrl_rdy_clr);
  wire reply_rdy_d = reply_rdy_set | (reply_rdy_q & ~reply_rdy_clr);
  wire aux_reply_rdy_d = aux_reply_rdy_set |
    (aux_reply_rdy_q & ~aux_reply_rdy_clr);

  // ready flags reset low; the control ones rise on the core's first dummy read
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_rdy_q <= 1'b0;
    end
    else
    begin
      ctrl_rdy_q <= ctrl_rdy_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aux_ctrl_rdy_q <= 1'b0;
    end
    else
    begin
      aux_ctrl_rdy_q <= aux_ctrl_rdy_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reply_rdy_q <= 1'b0;
    end
    else
    begin
      reply_rdy_q <= reply_rdy_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aux_reply_rdy_q <= 1'b0;
    end
    else
    begin
      aux_reply_rdy_q <= aux_reply_rdy_d;
    end
  end

  // rx ownership clear is done by the buffer block; we only mirror it
  wire rx_rdy = rx_buffer_owned;
  wire tx_dma_flag = tx_dreq_s & tx_dma_en;
  wire rx_dma_flag = rx_dreq_s & rx_dma_en;

  // each source is qualified by its own enable before the master gate
  wire rx_irq_src = rx_rdy & rx_ie;
  wire reply_irq_src = reply_rdy_q & reply_ie;
  wire aux_irq_src = aux_reply_rdy_q & aux_reply_ie;
  wire irq_src = rx_irq_src | reply_irq_src | aux_irq_src;
  wire host_irq = irq_src & master_ie;

  // registered so the pin never glitches while enables change
  wire pin_d = host_irq;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pin_q <= 1'b0;
    else
      pin_q <= pin_d;
  end
  assign host_interrupt_n = ~pin_q;
  wire pin_mirror = pin_q & master_ie;

  // status word; with the sleep flag up the other bits carry no meaning,
  // so they are forced to zero rather than left floating
  word_t status_raw;
  always_comb
  begin
    status_raw = 16'h0000;
    status_raw[`ST_CTRL_RDY] = ctrl_rdy_q;
    status_raw[`ST_AUX_CTRL_RDY] = aux_ctrl_rdy_q;
    status_raw[`ST_REPLY_RDY] = reply_rdy_q;
    status_raw[`ST_AUX_REPLY_RDY] = aux_reply_rdy_q;
    status_raw[`ST_RX_RDY] = rx_rdy;
    status_raw[`ST_TX_RDY] = tx_buffer_owned;
    status_raw[`ST_RX_DMA] = rx_dma_flag;
    status_raw[`ST_TX_DMA] = tx_dma_flag;
    status_raw[`ST_PIN_MIRROR] = pin_mirror;
  end
  word_t status_word;
  assign status_word = interface_sleep_flag ?
    16'h4000 : status_raw;

  // software interrupt status: events set, write one clears, set wins
  logic rx_rdy_q;
  wire ev_rx_rise = rx_rdy & ~rx_rdy_q;
  wire ev_cmd_taken = core_cmd_rd | core_aux_cmd_rd;
  wire [`IRQ_BITS-1:0] events = {
    core_aux_reply_wr, core_reply_wr, ev_cmd_taken, ev_rx_rise};
  wire wr_ist = wr && sel_ist;
  wire wr_msk = wr && sel_msk;
  wire [`IRQ_BITS-1:0] w1c = wr_ist ?
    wdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
  wire [`IRQ_BITS-1:0] irq_status_d = events | (irq_status_q & ~w1c);
  wire [`IRQ_BITS-1:0] irq_mask_d = wr_msk ?
    wdata[`IRQ_BITS-1:0] : irq_mask_q;
  // a one-cycle pulse; the stored control bit only serves read back
  wire wake_d = wr_ctrl & wdata[`CT_WAKE];

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_status_q <= {`IRQ_BITS{1'b0}};
    else
      irq_status_q <= irq_status_d;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask_q <= {`IRQ_BITS{1'b0}};
    else
      irq_mask_q <= irq_mask_d;
  end

  // edge detector starts low, as the buffer is not handed over at reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rx_rdy_q <= 1'b0;
    else
      rx_rdy_q <= rx_rdy;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      wake_q <= 1'b0;
    else
      wake_q <= wake_d;
  end

  assign irq = |(irq_status_q & irq_mask_q);
  assign wake_pulse = wake_q;

  // read mux; unmapped offsets read zero
  word_t rd_mux;
  always_comb
  begin
    case (addr)
      `OFF_HW_STATUS: rd_mux = status_word;
      `OFF_HW_CONTROL: rd_mux = hw_control_q;
      `OFF_CMD: rd_mux = cmd_q;
      `OFF_AUX_CMD: rd_mux = aux_cmd_q;
      `OFF_REPLY: rd_mux = reply_q;
      `OFF_AUX_REPLY: rd_mux = aux_reply_q;
      `OFF_IRQ_STATUS: rd_mux = {12'h000, irq_status_q};
      `OFF_IRQ_MASK: rd_mux = {12'h000, irq_mask_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // read data stand for one cycle after the strobe, zero otherwise
  wire word_t rdata_d = rd ? rd_mux : `WORD_RESET;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= `WORD_RESET;
    else
      rdata_q <= rdata_d;
  end
  assign rdata = rdata_q;
  assign core_cmd = cmd_q;
  assign core_aux_cmd = aux_cmd_q;

endmodule

// ---- mailbox_checker.sv ----
/* port checker for the mailbox, bound to it below.
   assumes mailbox_pkg and mailbox_params.svh compiled first. */
`timescale 1ns/1ps
`include "mailbox_params.svh"
module mailbox_checker
  import mailbox_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire reg_addr_t addr,
  input wire word_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire word_t rdata,
  input wire word_t core_cmd,
  input wire logic core_reply_wr,
  input wire logic core_aux_reply_wr,
  input wire logic host_reply_hi_rd,
  input wire logic host_aux_reply_hi_rd,
  input wire logic interface_sleep,
  input wire logic host_interrupt_n
);
  // control word is internal, so shadow it from bus writes
  word_t ctl_q;
  wire logic st_rd = rd && addr == `OFF_HW_STATUS;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      ctl_q <= `HW_CONTROL_RESET;
    else if (wr && addr == `OFF_HW_CONTROL)
      ctl_q <= wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_cmd_load: assert property (
    wr && addr == `OFF_CMD |=> core_cmd == $past(wdata))
    else $error("cmd load");
  a_cmd_back: assert property (
    rd && addr == `OFF_CMD |=> rdata == $past(core_cmd))
    else $error("cmd readback");
  a_dma_gate: assert property (
    st_rd && !ctl_q[`CT_TX_DMA_EN] && !ctl_q[`CT_RX_DMA_EN]
    |=> rdata[7:6] == 2'b00)
    else $error("dma not gated");
  a_pin_mirror: assert property (
    st_rd && $stable(host_interrupt_n)
    |=> !rdata[`ST_PIN_MIRROR] || !$past(host_interrupt_n))
    else $error("pin mirror");
  a_sleep_read: assert property (
    interface_sleep [*4] ##0 st_rd |=> rdata == 16'h4000)
    else $error("sleep status");
  a_master_off: assert property (
    !ctl_q[`CT_MASTER_IE] |=> host_interrupt_n)
    else $error("irq without master");
  a_reply_irq: assert property (
    core_reply_wr ##1 !host_reply_hi_rd
    ##1 (ctl_q[`CT_REPLY_IE] && ctl_q[`CT_MASTER_IE])
    |=> !host_interrupt_n)
    else $error("reply irq");
  a_aux_irq: assert property (
    core_aux_reply_wr ##1 !host_aux_reply_hi_rd
    ##1 (ctl_q[`CT_AUX_REPLY_IE] && ctl_q[`CT_MASTER_IE])
    |=> !host_interrupt_n)
    else $error("aux reply irq");
endmodule
bind host_status_command_mailbox mailbox_checker chk_u (.*);

// ---- host_bus_model.sv ----
/* host bus master model: one-cycle strobes, read data taken next cycle.
   assumes a slave that never stalls. */
`timescale 1ns/1ps
module host_bus_model
  import mailbox_pkg::*;
(
  input wire logic core_clk,
  input wire word_t rdata,
  output reg_addr_t addr,
  output word_t wdata,
  output logic wr,
  output logic rd
);
  initial {addr, wdata, wr, rd} = '0;
  task automatic put(input reg_addr_t a, input word_t d);
    @(posedge core_clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    // idle lines never keep a stale value
    {addr, wdata, wr} <= {~a, ~d, 1'b0};
  endtask
  task automatic get(input reg_addr_t a, output word_t d);
    @(posedge core_clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge core_clk);
    {addr, rd} <= {~a, 1'b0};
    @(posedge core_clk);
    d = rdata;
  endtask
endmodule

// ---- tb.sv ----
/* mailbox bench: random command and reply words plus corner cases.
   assumes the host bus model and the bound checker. */
`timescale 1ns/1ps
`include "mailbox_params.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb
  import mailbox_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sb = 8'h00;
  logic rx_buffer_owned = 1'b0;
  logic tx_buffer_owned = 1'b0;
  logic tx_dma_request = 1'b0;
  logic rx_dma_request = 1'b0;
  logic interface_sleep = 1'b0;
  word_t core_wdata = 16'h0000;
  word_t rdata, wdata, core_cmd, core_aux_cmd, d, w;
  reg_addr_t addr, a;
  logic wr, rd, host_interrupt_n, wake_pulse, irq;
  int n_errors = 0;
  int n_tests = 0;
  always #5 core_clk = ~core_clk;
  host_bus_model host_u (.*);
  host_status_command_mailbox dut_u (.*, .core_cmd_rd(sb[0]),
    .core_aux_cmd_rd(sb[1]), .core_reply_wr(sb[2]),
    .core_aux_reply_wr(sb[3]), .host_cmd_hi_wr(sb[4]),
    .host_aux_cmd_hi_wr(sb[5]), .host_reply_hi_rd(sb[6]),
    .host_aux_reply_hi_rd(sb[7]));
  function automatic logic [1:0] dma_exp(input logic [1:0] en);
    return {en[0], en[1]};
  endfunction
  task automatic pulse(input logic [7:0] v);
    @(posedge core_clk);
    sb <= v;
    @(posedge core_clk);
    sb <= 8'h00;
  endtask
  task automatic final_report;
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    final_report;
  end
  initial
  begin
    void'($urandom(32'h5f7a_03ed));
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    host_u.get(`OFF_HW_STATUS, d);
    `CHK("st_rst", 16'h0000, d)
    pulse(8'h03);
    host_u.get(`OFF_HW_STATUS, d);
    `CHK("ctl_rdy", 2'b11, d[1:0])
    for (int i = 0; i < 4; i++)
    begin
      w = (i == 0) ? 16'hffff : word_t'($urandom);
      a = i[0] ? `OFF_AUX_CMD : `OFF_CMD;
      host_u.put(a, w);
      host_u.get(a, d);
      `CHK("cmd", w, d)
      `CHK("core_cmd", w, i[0] ? core_aux_cmd : core_cmd)
      host_u.get(`OFF_HW_STATUS, d);
      `CHK("ctl_clr", 1'b0, d[i[0]])
      pulse(i[0] ? 8'h02 : 8'h01);
    end
    host_u.put(8'h20, ~w);
    host_u.get(`OFF_AUX_CMD, d);
    `CHK("unmapped", w, d)
    pulse(8'h30);
    host_u.get(`OFF_HW_STATUS, d);
    `CHK("hi_wr", 2'b00, d[1:0])
    for (int k = 0; k < 2; k++)
    begin
      w = word_t'($urandom);
      core_wdata <= w;
      host_u.put(`OFF_HW_CONTROL, k ? 16'h0024 : 16'h0022);
      pulse(k ? 8'h08 : 8'h04);
      repeat (2) @(posedge core_clk);
      `CHK("irq_set", 1'b0, host_interrupt_n)
      host_u.get(k ? `OFF_AUX_REPLY : `OFF_REPLY, d);
      `CHK("reply", w, d)
      pulse(k ? 8'h80 : 8'h40);
      repeat (2) @(posedge core_clk);
      `CHK("irq_clr", 1'b1, host_interrupt_n)
    end
    {tx_dma_request, rx_dma_request} <= 2'b11;
    for (int e = 0; e < 4; e++)
    begin
      host_u.put(`OFF_HW_CONTROL, 16'(e) << 3);
      repeat (3) @(posedge core_clk);
      host_u.get(`OFF_HW_STATUS, d);
      `CHK("dma", dma_exp(e[1:0]), d[7:6])
    end
    {rx_buffer_owned, tx_buffer_owned} <= 2'b11;
    host_u.put(`OFF_HW_CONTROL, 16'h0021);
    repeat (3) @(posedge core_clk);
    host_u.get(`OFF_HW_STATUS, d);
    `CHK("rx_rdy", 1'b1, d[4])
    `CHK("mirror", 1'b1, d[15])
    `CHK("irq_rx", 1'b0, host_interrupt_n)
    host_u.put(`OFF_HW_CONTROL, 16'h0001);
    repeat (3) @(posedge core_clk);
    host_u.get(`OFF_HW_STATUS, d);
    `CHK("mirror_off", 1'b0, d[15])
    `CHK("irq_off", 1'b1, host_interrupt_n)
    rx_buffer_owned <= 1'b0;
    host_u.get(`OFF_HW_STATUS, d);
    `CHK("rx_clr", 1'b0, d[4])
    host_u.put(`OFF_IRQ_MASK, 16'h0000);
    host_u.put(`OFF_IRQ_STATUS, 16'h000f);
    pulse(8'h04);
    host_u.put(`OFF_IRQ_MASK, 16'h0004);
    #1;
    `CHK("irq_on", 1'b1, irq)
    host_u.put(`OFF_IRQ_STATUS, 16'h0004);
    #1;
    `CHK("irq_w1c", 1'b0, irq)
    @(posedge core_clk);
    interface_sleep <= 1'b1;
    repeat (4) @(posedge core_clk);
    host_u.get(`OFF_HW_STATUS, d);
    `CHK("sleep", 16'h4000, d)
    interface_sleep <= 1'b0;
    host_u.put(`OFF_HW_CONTROL, 16'h0040);
    #1;
    `CHK("wake", 1'b1, wake_pulse)
    @(posedge core_clk);
    #1;
    `CHK("wake_end", 1'b0, wake_pulse)
    final_report;
  end
endmodule
